// *** dv/ewg_bus_master.sv ***
`timescale 1ns/10ps
// Behavioural two-wire bus master; SCL rests high between frames.
module ewg_bus_master (
	// Device side of the wire.
	input wire logic dev_o,
	input wire logic dev_oe,
	// Bus lines.
	output logic scl,
	output logic sda
);
	localparam int QTR = 625;
	logic m_oe = 1'b0;
	initial scl = 1'b1;
	// Pull-up wire: the device level counts only while it drives; the master pulls low.
	assign sda = (dev_o || !dev_oe) && !m_oe;
	// Data moves only while SCL is low and is sampled in the middle of the high phase.
	task automatic bit_io(input logic b, output logic s);
		m_oe = !b;
		#QTR scl = 1'b1;
		#QTR s = sda;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	task automatic start();
		m_oe = 1'b0;
		#QTR scl = 1'b1;
		#QTR m_oe = 1'b1;
		#QTR scl = 1'b0;
		#QTR;
	endtask
	// Leaves SCL high and SDA released, the idle state.
	task automatic stop();
		m_oe = 1'b1;
		#QTR scl = 1'b1;
		#QTR m_oe = 1'b0;
		#QTR;
	endtask
	// Byte out, most significant bit first; a is the device acknowledge.
	task automatic send(input logic [7:0] b, output logic a);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'b1, s);
		a = !s;
	endtask
	// Byte in; more asks for the next byte, otherwise the acknowledge is withheld.
	task automatic recv(input logic more, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!more, s);
	endtask
	// Address setup, repeated start, then read select.
	task automatic rd_at(input logic [6:0] id, input logic [7:0] adr, output logic a);
		start();
		send({id, 1'b0}, a);
		send(adr, a);
		start();
		send({id, 1'b1}, a);
	endtask
	// One framed write; aa is the address acknowledge, ad the data acknowledge.
	task automatic wr(input logic [6:0] id, input logic [7:0] adr, input logic [7:0] v,
		output logic aa, output logic ad);
		start();
		send({id, 1'b0}, ad);
		send(adr, aa);
		send(v, ad);
		stop();
	endtask
endmodule // ewg_bus_master

// *** dv/ewg_guard_seq_read_tb_top.sv ***
`timescale 1ns/10ps
module ewg_guard_seq_read_tb_top;
	import ewg_pkg::*;
	localparam int TWC = 400;
	logic core_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic nv_clear = 1'b1;
	logic wp_i = 1'b0;
	logic scl, sda, sda_o, sda_oe, nv_busy, pot_write_ok, pot_nv_write_ok;
	logic [31:0] lfsr = 32'h0001_5D1C;
	logic [7:0] mem [256];
	logic [7:0] wa [9] = '{8'hFE, 8'hFF, 8'h00, 8'h01, 8'h02, 8'h7F, 8'h80, 8'hBF, 8'hC0};
	int fails = 0;
	int num_checks = 0;

	// The link clock is offset so its edges never line up with the core clock.
	initial forever #50 core_clk = !core_clk;
	initial begin
		#7;
		forever #15 link_clk = !link_clk;
	end

	ewg_guard_seq_read #(.TWC_CYCLES(TWC)) u_ewg_guard_seq_read (.core_clk(core_clk),
		.rst(rst), .nv_clear(nv_clear), .link_clk(link_clk), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .nv_busy(nv_busy),
		.pot_write_ok(pot_write_ok), .pot_nv_write_ok(pot_nv_write_ok));
	ewg_bus_master u_ewg_bus_master (.dev_o(sda_o), .dev_oe(sda_oe), .scl(scl), .sda(sda));

	////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic locked(input logic [1:0] l, input logic [7:0] a);
		return l == EWG_LOCK_ALL || (l == EWG_LOCK_HALF && a >= EWG_LOCK_H_BASE)
			|| (l == EWG_LOCK_QUARTER && a >= EWG_LOCK_Q_BASE);
	endfunction
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Busy shows a few core edges after STOP; the wait is bounded so a hang is caught.
	task automatic settle();
		int n;
		n = 0;
		repeat (8) @(posedge core_clk);
		while (nv_busy !== 1'b0 && n < 1000) begin
			@(posedge core_clk);
			n++;
		end
		check("store end", 8'h00, {7'h00, nv_busy});
	endtask
	task automatic wr(input logic [6:0] id, input logic [7:0] adr, input logic [7:0] v,
		output logic aa, output logic ad);
		u_ewg_bus_master.wr(id, adr, v, aa, ad);
		settle();
	endtask
	task automatic reg_chk(input logic [7:0] exp);
		logic a;
		logic [7:0] d;
		u_ewg_bus_master.rd_at(EWG_ID_CS, EWG_CS_ADDR, a);
		u_ewg_bus_master.recv(1'b0, d);
		u_ewg_bus_master.stop();
		check("control_status", exp, d);
	endtask
	task automatic set_lock(input logic [1:0] l);
		logic aa, ad;
		wr(EWG_ID_CS, EWG_CS_ADDR, EWG_WEN_ONLY, aa, ad);
		wr(EWG_ID_CS, EWG_CS_ADDR, 8'h06, aa, ad);
		wr(EWG_ID_CS, EWG_CS_ADDR, {3'h0, l, 3'h2}, aa, ad);
	endtask
	task automatic ee_wr(input logic [7:0] adr, input logic [1:0] l);
		logic aa, ad;
		lfsr = lfsr_next(lfsr);
		wr(EWG_ID_EE, adr, lfsr[7:0], aa, ad);
		check("address ack", {7'h00, !locked(l, adr)}, {7'h00, aa});
		if (!locked(l, adr)) mem[adr] = lfsr[7:0];
	endtask
	task automatic seq_chk(input logic [7:0] adr, input int n);
		logic a;
		logic [7:0] d;
		u_ewg_bus_master.rd_at(EWG_ID_EE, adr, a);
		for (int i = 0; i < n; i++) begin
			u_ewg_bus_master.recv(i < n - 1, d);
			check("array byte", mem[8'(adr + i)], d);
		end
		u_ewg_bus_master.stop();
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence; random bytes fill the wrap corner and the lock boundaries.
	initial begin
		logic aa, ad;
		logic [7:0] d;
		repeat (4) @(posedge core_clk);
		#5;
		rst = 1'b0;
		nv_clear = 1'b0;
		repeat (4) @(posedge core_clk);
		reg_chk(EWG_BYTE_RESET);
		u_ewg_bus_master.wr(EWG_ID_EE, 8'h10, 8'h5A, aa, ad);
		check("data ack latch clear", 8'h00, {7'h00, ad});
		u_ewg_bus_master.wr(EWG_ID_CS, 8'hFE, EWG_WEN_ONLY, aa, ad);
		check("register address ack", 8'h00, {7'h00, aa});
		u_ewg_bus_master.wr(EWG_ID_CS, EWG_CS_ADDR, EWG_WEN_ONLY, aa, ad);
		repeat (8) @(posedge core_clk);
		check("busy after latch write", 8'h00, {7'h00, nv_busy});
		check("pot write ok", 8'h01, {7'h00, pot_write_ok});
		reg_chk(EWG_WEN_ONLY);
		// Right after a register access only a random read may reach the array.
		u_ewg_bus_master.start();
		u_ewg_bus_master.send({EWG_ID_EE, 1'b1}, aa);
		u_ewg_bus_master.stop();
		check("current read after register", 8'h00, {7'h00, aa});
		u_ewg_bus_master.wr(EWG_ID_EE, 8'h30, 8'hC3, aa, ad);
		u_ewg_bus_master.start();
		u_ewg_bus_master.send({EWG_ID_EE, 1'b0}, aa);
		u_ewg_bus_master.stop();
		check("ack during store", 8'h00, {7'h00, aa});
		settle();
		foreach (wa[i]) ee_wr(wa[i], EWG_LOCK_NONE);
		seq_chk(8'hFE, 4);
		u_ewg_bus_master.start();
		u_ewg_bus_master.send({EWG_ID_EE, 1'b1}, aa);
		u_ewg_bus_master.recv(1'b0, d);
		u_ewg_bus_master.stop();
		check("current read", mem[8'h02], d);
		for (int l = 3; l >= 0; l--) begin
			set_lock(2'(l));
			reg_chk({3'h0, 2'(l), 3'h2});
			check("pot write ok", {7'h00, l == 0}, {7'h00, pot_write_ok});
			wr(EWG_ID_CS, EWG_CS_ADDR, 8'h06, aa, ad);
			for (int k = 5; k < 9; k++) ee_wr(wa[k], 2'(l));
			reg_chk({3'h0, 2'(l), l == 0, 2'h2});
		end
		seq_chk(8'h7F, 2);
		seq_chk(8'hBF, 2);
		@(posedge core_clk);
		#5;
		wp_i = 1'b1;
		repeat (8) @(posedge core_clk);
		check("pot nv write ok", 8'h00, {7'h00, pot_nv_write_ok});
		u_ewg_bus_master.wr(EWG_ID_EE, 8'h01, 8'h00, aa, ad);
		check("data ack protect pin", 8'h00, {7'h00, ad});
		wr(EWG_ID_CS, EWG_CS_ADDR, 8'h1A, aa, ad);
		reg_chk(EWG_WEN_ONLY);
		@(posedge core_clk);
		#5;
		wp_i = 1'b0;
		wr(EWG_ID_CS, EWG_CS_ADDR, 8'h06, aa, ad);
		wr(EWG_ID_CS, EWG_CS_ADDR, 8'h1E, aa, ad);
		reg_chk(8'h06);
		check("pot nv write ok", 8'h01, {7'h00, pot_nv_write_ok});
		u_ewg_bus_master.start();
		u_ewg_bus_master.send({EWG_ID_CS, 1'b0}, aa);
		u_ewg_bus_master.send(EWG_CS_ADDR, aa);
		u_ewg_bus_master.send(EWG_WEN_ONLY, aa);
		u_ewg_bus_master.send(8'h00, aa);
		u_ewg_bus_master.stop();
		check("second byte ack", 8'h00, {7'h00, aa});
		settle();
		reg_chk(8'h06);
		wr(EWG_ID_CS, EWG_CS_ADDR, EWG_BYTE_RESET, aa, ad);
		u_ewg_bus_master.wr(EWG_ID_CS, EWG_CS_ADDR, 8'h06, aa, ad);
		check("latch set without enable", 8'h00, {7'h00, ad});
		reg_chk(EWG_BYTE_RESET);
		// A reset in mid-run clears the latches but must keep the stored lock code.
		set_lock(EWG_LOCK_HALF);
		@(posedge core_clk);
		#5;
		rst = 1'b1;
		repeat (4) @(posedge core_clk);
		#5;
		rst = 1'b0;
		repeat (4) @(posedge core_clk);
		reg_chk({3'h0, EWG_LOCK_HALF, 3'h0});
		end_sim();
	end

	// Watchdog sized well above the expected run length.
	initial begin
		repeat (90000) @(posedge core_clk);
		fails++;
		end_sim();
	end
endmodule // ewg_guard_seq_read_tb_top

// *** hdl/ewg_guard_seq_read.sv ***
`timescale 1ns/10ps
// Function
// RULE1 - Sequential read starts from current or random address.
// RULE2 - Each master acknowledge sends next address byte.
// RULE3 - Master ends read with no acknowledge, STOP.
// RULE4 - Read counter wraps from last location to 00h.
// RULE5 - Register layout: 000, lock bits, latches, 0.
// RULE6 - Lock bits persist; volatile latches power up zero.
// RULE7 - Writes without write enable latch get no acknowledge.
// RULE8 - 02h sets write enable latch; 00h clears it.
// RULE9 - Latch-only register writes start no store cycle.
// RULE10 - Other bits need register latch; that needs enable.
// RULE11 - Master uses three writes: 02h, 06h, value.
// RULE12 - Register latch clears after store or locked attempt.
// RULE13 - Lock codes protect none, C0-FF, 80-FF, all.
// RULE14 - Writes to locked addresses leave array unchanged.
// RULE15 - Nonzero lock code refuses potentiometer wiper writes.
// RULE16 - Lock bits leave factory as 00.
// RULE17 - Write-protect pin blocks array and potentiometer stores.
// RULE18 - Write-protect pin ignores register nonvolatile bit writes.
// RULE19 - Register selected by id 1010010, address FFh.
// RULE20 - One data byte per register write; more aborts.
// RULE21 - STOP after value write starts timed lock store.
// RULE22 - Value with bit 2 set keeps lock bits unchanged.
// RULE23 - Master writes zeros to reserved register bits.
// RULE24 - Locked array write refused at address acknowledge.
// RULE25 - During store cycle bus is ignored, data released.
// RULE26 - Shared 8-bit address counter increments per sent byte.
module ewg_guard_seq_read
	import ewg_pkg::*;
#(
	parameter int TWC_CYCLES = EWG_TWC_CYCLES
) (
	// Core clock domain.
	input wire logic core_clk,
	input wire logic rst,
	input wire logic nv_clear,
	// Two-wire bus, sampled on the link clock.
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Write-protect pin.
	input wire logic wp_i,
	// Status towards the rest of the device.
	output logic nv_busy,
	output logic pot_write_ok,
	output logic pot_nv_write_ok
);

	////////////////////////////////////////////////////////////
	// Core domain: self-timed store cycle and nonvolatile lock bits.
	logic req_meta;
	logic req_sync;
	logic done_tog;
	logic [22:0] twc_cnt;
	logic [1:0] lock_nv;
	logic [1:0] lock_stage;
	logic nv_req_tog;
	// The end point is one short of the count, so busy lasts exactly TWC_CYCLES clocks.
	wire twc_end = nv_busy && (twc_cnt == 23'(TWC_CYCLES - 1));

	// A toggle from the link side starts one store; the done toggle closes it.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			done_tog <= 1'b0;
			nv_busy <= 1'b0;
			twc_cnt <= '0;
		end else begin
			req_meta <= nv_req_tog;
			req_sync <= req_meta;
			if (!nv_busy && (req_sync != done_tog)) begin
				nv_busy <= 1'b1; // RULE21
				twc_cnt <= '0;
			end else if (twc_end) begin
				nv_busy <= 1'b0;
				done_tog <= req_sync;
			end else if (nv_busy) begin
				twc_cnt <= twc_cnt + 23'h1;
			end
		end
	end

	// Lock bits survive rst, as a power cycle would leave them; only the
	// factory clear and the end of a store cycle load them. The staged value is stable for the whole cycle.
	always_ff @(posedge core_clk) begin
		if (nv_clear) begin
			lock_nv <= EWG_LOCK_NONE; // RULE16
		end else if (twc_end) begin
			lock_nv <= lock_stage; // RULE6
		end
	end

	a_store_hold: assert property (@(posedge core_clk) disable iff (rst) // RULE21
		$rose(nv_busy) |-> nv_busy[*8])
		else $error("Store cycle ended too early.");

	////////////////////////////////////////////////////////////
	// Link domain: synchronisers.
	logic rst_meta, rst_l;
	logic scl_meta, scl_s, scl_d;
	logic sda_meta, sda_s, sda_d;
	logic wp_meta, wp_s;
	logic done_meta, done_s;
	logic [1:0] lock_meta, lock_s;

	// The lock bits only change while the link is held off, so a plain
	// two-stage pass of both bits cannot be seen half updated.
	always_ff @(posedge link_clk) begin
		rst_meta <= rst;
		rst_l <= rst_meta;
		scl_meta <= scl_i;
		scl_s <= scl_meta;
		scl_d <= scl_s;
		sda_meta <= sda_i;
		sda_s <= sda_meta;
		sda_d <= sda_s;
		wp_meta <= wp_i;
		wp_s <= wp_meta;
		done_meta <= done_tog;
		done_s <= done_meta;
		lock_meta <= lock_nv;
		lock_s <= lock_meta;
	end

	////////////////////////////////////////////////////////////
	// Link domain: decode.
	ewg_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [1:0] byte_idx;
	logic cs_sel, rd, last_cs, pend;
	logic [7:0] addr_cnt;
	logic [7:0] wr_data;
	logic write_enable_latch;
	logic register_write_enable_latch;
	logic [7:0] mem [256];
	ewg_cs_t cs_read;
	ewg_cs_t cs_wr;

	// The store request stays open until the done toggle returns; while it is
	// open the engine takes no new START.
	wire busy_l = (nv_req_tog != done_s);
	wire scl_rise = scl_s && !scl_d;
	wire scl_fall = !scl_s && scl_d;
	wire start_c = scl_s && scl_d && sda_d && !sda_s;
	wire stop_c = scl_s && scl_d && !sda_d && sda_s;
	wire byte_end = (state == EWG_RX) && scl_fall && (bit_cnt == EWG_BITS_BYTE);
	wire id_ee = (shreg[7:1] == EWG_ID_EE);
	wire id_cs = (shreg[7:1] == EWG_ID_CS); // RULE19
	// Locked region check on the address byte just received.
	wire lock_hit = (lock_s == EWG_LOCK_ALL)
		|| ((lock_s == EWG_LOCK_HALF) && (shreg >= EWG_LOCK_H_BASE))
		|| ((lock_s == EWG_LOCK_QUARTER) && (shreg >= EWG_LOCK_Q_BASE)); // RULE13
	wire ack_dev = (id_ee && !(shreg[0] && last_cs)) || id_cs;
	wire ack_addr = cs_sel ? (shreg == EWG_CS_ADDR) : !lock_hit; // RULE19 RULE24
	// Without the enable latch only a latch-only byte reaches the register.
	wire ack_cs_data = write_enable_latch || !shreg[EWG_BIT_RWEN]; // RULE10
	wire ack_ee_data = write_enable_latch && !wp_s; // RULE7 RULE17
	wire ack_data = (byte_idx == EWG_IDX_DATA) && (cs_sel ? ack_cs_data : ack_ee_data); // RULE20
	// One acknowledge decision per byte position: select, address, then data.
	wire ack_now = (byte_idx == 2'h0) ? ack_dev : ((byte_idx == 2'h1) ? ack_addr : ack_data);
	wire ee_commit = stop_c && pend && !cs_sel; // RULE14
	wire cs_commit = stop_c && pend && cs_sel;
	wire lock_store = cs_commit && register_write_enable_latch && write_enable_latch
		&& !cs_wr.register_write_enable_latch && !wp_s; // RULE18 RULE22
	wire [7:0] tx_byte = cs_sel ? cs_read : mem[addr_cnt];

	// Reserved bits always read as zero.
	assign cs_read = '{reserved_upper_bits: 3'h0, lock_size: lock_s,
		register_write_enable_latch: register_write_enable_latch,
		write_enable_latch: write_enable_latch, reserved_lowest_bit: 1'b0}; // RULE5
	assign cs_wr = ewg_cs_t'(wr_data);

	////////////////////////////////////////////////////////////
	// Link domain: bus engine. Starts arriving during a store are ignored,
	// so the engine stays idle with the data line released.
	always_ff @(posedge link_clk) begin
		if (rst_l) begin
			state <= EWG_IDLE;
			bit_cnt <= '0;
			shreg <= EWG_BYTE_RESET;
			byte_idx <= '0;
			cs_sel <= 1'b0;
			rd <= 1'b0;
			last_cs <= 1'b0;
			pend <= 1'b0;
			addr_cnt <= EWG_BYTE_RESET;
			wr_data <= EWG_BYTE_RESET;
			sda_oe <= 1'b0;
			write_enable_latch <= 1'b0; // RULE6
			register_write_enable_latch <= 1'b0; // RULE6
			nv_req_tog <= 1'b0;
		end else if (start_c && !busy_l) begin
			state <= EWG_RX; // RULE25
			bit_cnt <= '0;
			byte_idx <= '0;
			pend <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			state <= EWG_IDLE;
			sda_oe <= 1'b0;
			pend <= 1'b0;
			if (ee_commit) begin
				nv_req_tog <= !nv_req_tog;
			end
			if (cs_commit) begin
				write_enable_latch <= cs_wr.write_enable_latch; // RULE8 RULE9
				if (cs_wr.register_write_enable_latch) begin
					register_write_enable_latch <= write_enable_latch; // RULE10 RULE22
				end else if (register_write_enable_latch) begin
					register_write_enable_latch <= 1'b0; // RULE12
				end
				if (lock_store) begin
					nv_req_tog <= !nv_req_tog; // RULE21
				end
			end
		end else begin
			case (state)
				EWG_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_end) begin
						bit_cnt <= '0;
						byte_idx <= (byte_idx == EWG_IDX_EXTRA) ? byte_idx : byte_idx + 2'h1;
						if (ack_now) begin
							sda_oe <= 1'b1;
							state <= EWG_RX_ACK;
							if (byte_idx == 2'h0) begin
								cs_sel <= id_cs;
								last_cs <= id_cs;
								rd <= shreg[0];
							end else if ((byte_idx == 2'h1) && !cs_sel) begin
								addr_cnt <= shreg; // RULE1
							end else if (byte_idx == EWG_IDX_DATA) begin
								pend <= 1'b1;
								wr_data <= shreg;
							end
						end else begin
							state <= EWG_IDLE; // RULE7
							pend <= 1'b0; // RULE20
							if ((byte_idx == 2'h1) && !cs_sel) begin
								register_write_enable_latch <= 1'b0; // RULE12
							end
						end
					end
				end
				EWG_RX_ACK: begin
					if (scl_fall) begin
						if (rd) begin
							state <= EWG_TX; // RULE1
							shreg <= tx_byte;
							sda_oe <= !tx_byte[7];
						end else begin
							state <= EWG_RX;
							sda_oe <= 1'b0;
						end
					end
				end
				EWG_TX: begin
					if (scl_fall) begin
						// The counter steps as the last bit leaves, so the next byte and a
						// later current read both start from the following address.
						if (bit_cnt == EWG_BIT_LAST) begin
							sda_oe <= 1'b0;
							state <= EWG_TX_ACK;
							bit_cnt <= '0;
							if (!cs_sel) begin
								addr_cnt <= addr_cnt + 8'h01; // RULE4 RULE26
							end
						end else begin
							shreg <= {shreg[6:0], 1'b0};
							sda_oe <= !shreg[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				EWG_TX_ACK: begin
					// The register gives one byte only; the array keeps going.
					if (scl_rise) begin
						if (sda_s || cs_sel) begin
							state <= EWG_IDLE; // RULE3
						end else begin
							bit_cnt <= EWG_BITS_BYTE;
						end
					end else if (scl_fall && (bit_cnt == EWG_BITS_BYTE)) begin
						state <= EWG_TX; // RULE2
						bit_cnt <= '0;
						shreg <= tx_byte;
						sda_oe <= !tx_byte[7];
					end
				end
				default: begin
					state <= EWG_IDLE;
				end
			endcase
		end
	end

	// The array stores only from an acknowledged, unlocked data byte.
	always_ff @(posedge link_clk) begin
		if (ee_commit) begin
			mem[addr_cnt] <= wr_data; // RULE14
		end
	end

	// Lock value handed to the core; stable until the done toggle returns.
	always_ff @(posedge link_clk) begin
		if (rst_l) begin
			lock_stage <= EWG_LOCK_NONE;
		end else if (lock_store) begin
			lock_stage <= cs_wr.lock_size; // RULE21
		end else if (ee_commit) begin
			lock_stage <= lock_s;
		end
	end

	// Potentiometer permissions and the open-drain low level.
	// The wiper datapath sits elsewhere; these two flags are all it needs
	// from this block.
	always_ff @(posedge link_clk) begin
		if (rst_l) begin
			sda_o <= 1'b0;
			pot_write_ok <= 1'b0;
			pot_nv_write_ok <= 1'b0;
		end else begin
			sda_o <= 1'b0;
			pot_write_ok <= write_enable_latch && (lock_s == EWG_LOCK_NONE); // RULE15
			pot_nv_write_ok <= write_enable_latch && (lock_s == EWG_LOCK_NONE) && !wp_s; // RULE17
		end
	end

	////////////////////////////////////////////////////////////
	// Checks on the link engine.
	a_busy_quiet: assert property (@(posedge link_clk) disable iff (rst_l) // RULE25
		busy_l && $past(busy_l) |-> !sda_oe && (state == EWG_IDLE))
		else $error("Bus driven during store cycle.");
	a_addr_wrap: assert property (@(posedge link_clk) disable iff (rst_l) // RULE4
		(state == EWG_TX) && scl_fall && (bit_cnt == EWG_BIT_LAST) && !cs_sel && !stop_c
		|=> addr_cnt == $past(addr_cnt) + 8'h01)
		else $error("Read address did not step.");
	a_next_byte: assert property (@(posedge link_clk) disable iff (rst_l) // RULE2
		(state == EWG_TX_ACK) && scl_fall && (bit_cnt == EWG_BITS_BYTE) && !stop_c && !start_c
		|=> (state == EWG_TX) && (sda_oe == !$past(tx_byte[7])))
		else $error("Next read byte not sent.");
	a_lock_nack: assert property (@(posedge link_clk) disable iff (rst_l) // RULE24
		byte_end && (byte_idx == 2'h1) && !cs_sel && lock_hit && !stop_c && !start_c
		|=> (state == EWG_IDLE) && !sda_oe && !register_write_enable_latch)
		else $error("Locked address acknowledged.");
	a_enable_nack: assert property (@(posedge link_clk) disable iff (rst_l) // RULE7
		byte_end && (byte_idx == EWG_IDX_DATA) && !cs_sel && !write_enable_latch
		&& !stop_c && !start_c |=> !sda_oe && !pend)
		else $error("Array data taken without enable.");
	a_protect_nack: assert property (@(posedge link_clk) disable iff (rst_l) // RULE17
		byte_end && (byte_idx == EWG_IDX_DATA) && !cs_sel && wp_s && !stop_c && !start_c
		|=> !sda_oe)
		else $error("Array data taken while protected.");
	a_one_byte: assert property (@(posedge link_clk) disable iff (rst_l) // RULE20
		byte_end && (byte_idx == EWG_IDX_EXTRA) && !stop_c && !start_c |=> !pend && !sda_oe)
		else $error("Extra byte acknowledged.");
	// With the register latch already set, a 02h value is a lock store of 00 and
	// rightly starts a cycle, so only the latch-only case is checked here.
	a_latch_set: assert property (@(posedge link_clk) disable iff (rst_l) // RULE8
		cs_commit && (wr_data == EWG_WEN_ONLY) && !register_write_enable_latch
		|=> write_enable_latch && !busy_l)
		else $error("Enable latch write misbehaved.");
	a_protect_reg: assert property (@(posedge link_clk) disable iff (rst_l) // RULE18
		cs_commit && wp_s |=> $stable(nv_req_tog))
		else $error("Lock store started while protected.");

endmodule // ewg_guard_seq_read

// *** hdl/ewg_pkg.sv ***
package ewg_pkg;
	// Two-wire bus device type codes and the register address byte.
	localparam logic [6:0] EWG_ID_EE = 7'h50;
	localparam logic [6:0] EWG_ID_CS = 7'h52;
	localparam logic [7:0] EWG_CS_ADDR = 8'hFF;
	// Lower bounds of the upper quarter and the upper half lock regions.
	localparam logic [7:0] EWG_LOCK_Q_BASE = 8'hC0;
	localparam logic [7:0] EWG_LOCK_H_BASE = 8'h80;
	localparam logic [1:0] EWG_LOCK_NONE = 2'h0;
	localparam logic [1:0] EWG_LOCK_QUARTER = 2'h1;
	localparam logic [1:0] EWG_LOCK_HALF = 2'h2;
	localparam logic [1:0] EWG_LOCK_ALL = 2'h3;
	// Bit positions inside the control/status register.
	localparam int EWG_BIT_WEN = 1;
	localparam int EWG_BIT_RWEN = 2;
	// Value after reset and the latch-only write value.
	localparam logic [7:0] EWG_BYTE_RESET = 8'h00;
	localparam logic [7:0] EWG_WEN_ONLY = 8'h02;
	// Self-timed store: 5 ms typical at a core clock of 100 ns.
	localparam int EWG_T_WC_NS = 5000000;
	localparam int EWG_CORE_PERIOD_NS = 100;
	localparam int EWG_TWC_CYCLES = EWG_T_WC_NS / EWG_CORE_PERIOD_NS;
	// Bit and byte counter values.
	localparam logic [3:0] EWG_BITS_BYTE = 4'h8;
	localparam logic [3:0] EWG_BIT_LAST = 4'h7;
	localparam logic [1:0] EWG_IDX_DATA = 2'h2;
	localparam logic [1:0] EWG_IDX_EXTRA = 2'h3;

	typedef struct packed {
		logic [2:0] reserved_upper_bits;
		logic [1:0] lock_size;
		logic register_write_enable_latch;
		logic write_enable_latch;
		logic reserved_lowest_bit;
	} ewg_cs_t;

	typedef enum logic [2:0] {EWG_IDLE, EWG_RX, EWG_RX_ACK, EWG_TX, EWG_TX_ACK} ewg_state_t;
endpackage
